//--- shared/lane_word_regs.vh
`ifndef LANE_WORD_REGS_VH
`define LANE_WORD_REGS_VH
// symbol values, dx.y packs as {y, x}
`define SYM_K28_7     8'hfc
`define SYM_K28_5     8'hbc
`define SYM_D14_6     8'hce
`define SYM_D17_1     8'h31
`define SYM_D31_3     8'h7f
`define SYM_D15_6     8'hcf
`define SYM_D6_2      8'h46
`define SYM_D25_5     8'hb9
`define SYM_D6_5      8'ha6
`define SYM_D25_2     8'h59
`define SYM_D24_1     8'h38
`define SYM_D30_3     8'h7e
`define SYM_D4_3      8'h64
`define SYM_ZERO      8'h00
`define K_COMMA_ONLY  4'h1
`define K_NONE        4'h0
// register byte addresses
`define REG_CTRL      4'h0
`define REG_STATUS    4'h4
`define REG_RXINFO    4'h8
`define CTRL_RESET    32'h00000000
// control fields
`define CTRL_MODE_HI  2
`define CTRL_MODE_LO  0
`define CTRL_FLUSH    3
`define CTRL_START    4
`define CTRL_SCRAM    5
`define CTRL_RUN      6
`define CTRL_UNINV    7
// transmit modes
`define MODE_RUN      3'h0
`define MODE_INIT_WORD_ONE    3'h1
`define MODE_INIT_WORD_TWO    3'h2
`define MODE_INIT_WORD_THREE    3'h3
`define MODE_STBY     3'h4
// capability and cause bit positions
`define CAP_FLUSH     0
`define CAP_START     1
`define CAP_SCRAM     2
`define CAUSE_ERRORS  0
`define STBY_NEEDED   4'h8
`define SKIP_MAX      5000
`define SKIP_W        13
`endif

//--- tb/lane_codec_props.sv
`timescale 1ns/1ps
module lane_codec_props #(
    parameter SKIP_INTERVAL = 8
) (
    input wire        clk,
    input wire        rst,
    input wire        tx_ready,
    input wire [31:0] tx_word,
    input wire [3:0]  tx_k,
    input wire [31:0] ql_word,
    input wire        ql_ack,
    input wire        rx_no_signal,
    input wire        rx_error_burst,
    input wire [31:0] rx_word,
    input wire [3:0]  rx_k,
    input wire        rx_valid,
    input wire        rx_invert,
    input wire        flush_request
);
    wire       rxk = rx_valid && rx_k == 4'h1;
    wire       rx_flush = rx_word[24];
    reg [15:0] gap;
    // bound loose by one so the count phase cannot raise a false alarm
    always @(posedge clk) begin
        if (rst)
            gap <= 16'h0000;
        else if (tx_ready)
            gap <= (tx_word == 32'h7f7fcefc) ? 16'h0000 : gap + 16'h0001;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_no_inv_one: assert property (tx_word != 32'hb9b931bc)
        else $error("inverted init one sent");
    a_no_inv_two: assert property (tx_word != 32'h595931bc)
        else $error("inverted init two sent");
    a_skip_gap: assert property (gap <= SKIP_INTERVAL)
        else $error("skip word overdue");
    a_id_second: assert property (tx_k == 4'h1 |-> tx_word[15:8] == 8'hce &&
        (tx_word[7:0] == 8'hfc || tx_word[7:0] == 8'hbc)) else $error("comma or id wrong");
    a_cap_reserved: assert property (tx_word[23:0] == 24'h38cebc |-> tx_word[31:27] == 5'h00)
        else $error("capability reserved bits set");
    a_loss_cause: assert property ($past(tx_ready) && tx_word[23:0] == 24'h64cefc |->
        tx_word[31:24] == {7'h00, $past(rx_error_burst) && !$past(rx_no_signal)}) else $error("bad cause");
    a_inv_toggle: assert property (rxk && rx_word == 32'hb9b931bc |=> rx_invert != $past(rx_invert))
        else $error("inversion not toggled");
    a_flush_pulse: assert property (rxk && rx_word[23:0] == 24'h38cebc |=> flush_request == $past(rx_flush))
        else $error("flush pulse wrong");
    a_ack_word: assert property (ql_ack |-> (tx_word == $past(ql_word)) ##1 !ql_ack)
        else $error("quality word not sent");
endmodule

//--- tb/lane_peer_model.sv
`timescale 1ns/1ps
module lane_peer_model (
    input  wire        clk,
    input  wire        slow,
    output reg         tx_ready,
    output reg  [31:0] rx_word,
    output reg  [3:0]  rx_k,
    output reg         rx_valid
);
    initial begin
        tx_ready = 1'b1;
        rx_word = 32'h00000000;
        rx_k = 4'h0;
        rx_valid = 1'b0;
    end
    // slow mode stalls the serializer every other cycle
    always @(posedge clk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    task send(input [31:0] w);
        begin
            @(posedge clk);
            rx_word <= w;
            rx_k <= 4'h1;
            rx_valid <= 1'b1;
            @(posedge clk);
            rx_valid <= 1'b0;
            rx_k <= 4'h0;
            rx_word <= ~w; // stale word must not look valid
        end
    endtask
endmodule

//--- tb/tb_lane_control_word_codec.sv
`timescale 1ns/1ps
`include "lane_word_regs.vh"
module tb_lane_control_word_codec;
    localparam SKIP_INTERVAL = 8;
    localparam [31:0] W_IDLE = 32'hcfcfcefc;
    localparam [31:0] W_SKIP = 32'h7f7fcefc;
    localparam [31:0] W_INIT_WORD_ONE = 32'h4646cebc;
    localparam [31:0] W_INIT_WORD_TWO = 32'ha6a6cebc;
    localparam [31:0] W_INIT_WORD_THREE = 32'h0038cebc;
    localparam [31:0] W_STBY = 32'h7e7ecefc;
    localparam [31:0] W_LOSS = 32'h0064cefc;
    localparam [63:0] LIST = 64'h04030b23133b0201;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg  [3:0]  avs_address = 4'h0;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h00000000;
    reg  [31:0] ql_word = 32'h00000000;
    reg         ql_valid = 1'b0;
    reg         rx_no_signal = 1'b0;
    reg         rx_error_burst = 1'b0;
    reg         slow = 1'b0;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest;
    wire        tx_ready;
    wire [31:0] tx_word;
    wire [3:0]  tx_k;
    wire        ql_ack;
    wire [31:0] rx_word;
    wire [3:0]  rx_k;
    wire        rx_valid;
    wire        rx_invert;
    wire [7:0]  pulses;
    integer     miscompares = 0;
    integer     checks = 0;
    integer     i;
    reg  [31:0] q;
    reg  [31:0] e;
    reg  [7:0]  c;
    always #12.5 clk = ~clk;
    lane_control_word_codec #(.SKIP_INTERVAL(SKIP_INTERVAL)) uut (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tx_ready(tx_ready), .tx_word(tx_word), .tx_k(tx_k), .ql_word(ql_word),
        .ql_k(4'h0), .ql_valid(ql_valid), .ql_ack(ql_ack), .rx_no_signal(rx_no_signal),
        .rx_error_burst(rx_error_burst), .rx_word(rx_word), .rx_k(rx_k), .rx_valid(rx_valid),
        .rx_invert(rx_invert), .rx_skip_seen(pulses[0]), .rx_idle_seen(pulses[1]), .rx_init_one_seen(pulses[2]),
        .rx_init_two_seen(pulses[3]), .rx_init_three_seen(pulses[4]), .rx_standby_seen(pulses[5]),
        .rx_loss_seen(pulses[6]), .flush_request(pulses[7]));
    lane_peer_model peer (.clk(clk), .slow(slow), .tx_ready(tx_ready), .rx_word(rx_word), .rx_k(rx_k),
        .rx_valid(rx_valid));
    task chk(input [31:0] g, input [31:0] x);
        begin
            checks = checks + 1;
            if (g !== x) begin
                miscompares = miscompares + 1;
                $display("Error at %0t: got %h expected %h", $time, g, x);
            end
        end
    endtask
    task bus(input w, input [3:0] a, input [31:0] d, output [31:0] r);
        integer n;
        begin
            n = 0;
            @(posedge clk);
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= w;
            avs_read <= ~w;
            do @(posedge clk); while (avs_waitrequest !== 1'b0 && ++n < 50);
            r = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            if (n >= 50) chk(32'h0, 32'h1);
        end
    endtask
    // window spans three skip intervals, one and a half when stalled
    task look(input [31:0] x, input want);
        integer k;
        reg f;
        begin
            f = 1'b0;
            for (k = 0; k < 24; k = k + 1) begin
                @(posedge clk);
                if (tx_word === x) f = 1'b1;
            end
            chk({31'h0, f}, {31'h0, want});
        end
    endtask
    task rcv(input [31:0] w, input [7:0] p);
        begin
            peer.send(w);
            #1 chk({24'h0, pulses}, {24'h0, p});
        end
    endtask
    task final_report;
        begin
            $display("checks %0d miscompares %0d", checks, miscompares);
            if (miscompares == 0 && checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    initial begin
        #(25 * 5000);
        miscompares = miscompares + 1;
        final_report;
    end
    initial begin
        repeat (8) @(posedge clk);
        chk(tx_word, W_IDLE);
        rst <= 1'b0;
        bus(1'b0, `REG_CTRL, 32'h0, q);
        chk(q, `CTRL_RESET);
        bus(1'b0, 4'hc, 32'hffffffff, q);
        chk(q, 32'h0);
        look(W_SKIP, 1'b1);
        look(W_IDLE, 1'b1);
        for (i = 0; i < 8; i = i + 1) begin
            c = LIST[i*8 +: 8];
            case (c[2:0])
                3'h1: e = W_INIT_WORD_ONE;
                3'h2: e = W_INIT_WORD_TWO;
                3'h3: e = W_INIT_WORD_THREE | {5'h00, c[5], c[4], c[3], 24'h0};
                default: e = W_STBY;
            endcase
            slow <= i[0];
            bus(1'b1, `REG_CTRL, {24'h0, c}, q);
            look(e, 1'b1);
        end
        slow <= 1'b0;
        bus(1'b1, `REG_CTRL, 32'h0, q);
        rx_no_signal <= 1'b1;
        look(W_LOSS, 1'b1);
        rx_no_signal <= 1'b0;
        rx_error_burst <= 1'b1;
        look(W_LOSS | 32'h01000000, 1'b1);
        rx_error_burst <= 1'b0;
        rcv(W_SKIP, 8'h01);
        rcv(W_IDLE, 8'h02);
        rcv(W_INIT_WORD_ONE, 8'h04);
        rcv(W_INIT_WORD_TWO, 8'h08);
        rcv(W_INIT_WORD_THREE | 32'h01000000, 8'h90);
        rcv(W_INIT_WORD_THREE | 32'hfe000000, 8'h10);
        rcv(W_LOSS | 32'h01000000, 8'h40);
        bus(1'b0, `REG_RXINFO, 32'h0, q);
        chk(q, 32'h00000106);
        peer.send(32'hb9b931bc);
        #1 chk({31'h0, rx_invert}, 32'h1);
        peer.send(32'h595931bc);
        #1 chk({31'h0, rx_invert}, 32'h0);
        peer.send(32'hb9b931bc);
        #1 chk({31'h0, rx_invert}, 32'h1);
        bus(1'b1, `REG_CTRL, 32'h80, q);
        @(posedge clk);
        #1 chk({31'h0, rx_invert}, 32'h0);
        rx_no_signal <= 1'b1;
        for (i = 0; i < 7; i = i + 1) rcv(W_STBY, 8'h20);
        look(W_LOSS, 1'b1);
        rcv(W_STBY, 8'h20);
        bus(1'b0, `REG_STATUS, 32'h0, q);
        chk(q, 32'h00000022);
        @(posedge clk);
        look(W_LOSS, 1'b0);
        rx_no_signal <= 1'b0;
        bus(1'b1, `REG_CTRL, 32'h40, q);
        ql_word <= 32'h5a3c0f21;
        ql_valid <= 1'b1;
        i = 0;
        do @(posedge clk); while (ql_ack !== 1'b1 && ++i < 50);
        chk(tx_word, 32'h5a3c0f21);
        ql_valid <= 1'b0;
        look(W_IDLE, 1'b1);
        final_report;
    end
endmodule
bind lane_control_word_codec lane_codec_props #(.SKIP_INTERVAL(SKIP_INTERVAL)) u_props (.clk(clk), .rst(rst),
    .tx_ready(tx_ready), .tx_word(tx_word), .tx_k(tx_k), .ql_word(ql_word), .ql_ack(ql_ack),
    .rx_no_signal(rx_no_signal), .rx_error_burst(rx_error_burst), .rx_word(rx_word), .rx_k(rx_k),
    .rx_valid(rx_valid), .rx_invert(rx_invert), .flush_request(flush_request));

//--- verilog/lane_control_word_codec.v
// How it works
// - skip word: comma k28.7 first, then id
// - every lane word carries id d14.6 second
// - skip word is k28.7 d14.6 d31.3 d31.3
// - receiver flags skip words for elastic buffer
// - idle words k28.7 d14.6 d15.6 d15.6
// - first init word k28.5 d14.6 d6.2 d6.2
// - detect inverted first init; never send it
// - second init word k28.5 d14.6 d6.5 d6.5
// - detect inverted second init; never send it
// - third init word k28.5 d14.6 d24.1 capability
// - capability bits: flush, start mode, scrambling
// - received flush flag one triggers flush
// - start flag: 0 auto, 1 explicit start
// - scrambling flag: 1 when data scrambled
// - standby words k28.7 d14.6 d30.3 d30.3
// - signal-loss words k28.7 d14.6 d4.3 cause
// - cause bit 0: 0 weak, 1 errors
// - eight standby words received suppress signal-loss
// - skip word at least every n words
// - idle when quality layer offers nothing
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "lane_word_regs.vh"
module lane_control_word_codec #(
    parameter SKIP_INTERVAL = `SKIP_MAX
) (
    input  wire        clk,
    input  wire        rst,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire        tx_ready,
    output reg  [31:0] tx_word,
    output reg  [3:0]  tx_k,
    input  wire [31:0] ql_word,
    input  wire [3:0]  ql_k,
    input  wire        ql_valid,
    output reg         ql_ack,
    input  wire        rx_no_signal,
    input  wire        rx_error_burst,
    input  wire [31:0] rx_word,
    input  wire [3:0]  rx_k,
    input  wire        rx_valid,
    output reg         rx_invert,
    output reg         rx_skip_seen,
    output reg         rx_idle_seen,
    output reg         rx_init_one_seen,
    output reg         rx_init_two_seen,
    output reg         rx_init_three_seen,
    output reg         rx_standby_seen,
    output reg         rx_loss_seen,
    output reg         flush_request
);

    // interval is held in 32 bits first, then cut to the counter width on purpose
    localparam [31:0]        SKIP_LAST_FULL = SKIP_INTERVAL - 1;
    localparam [`SKIP_W-1:0] SKIP_LAST      = SKIP_LAST_FULL[`SKIP_W-1:0];

    // builds a lane word, comma in the low symbol so it goes out first
    function [31:0] lane_word;
        input [7:0] comma;
        input [7:0] kind;
        input [7:0] last;
        begin
            lane_word = {last, kind, `SYM_D14_6, comma};
        end
    endfunction

    // compares the first three symbols and the k flags of a word
    function head_match;
        input [31:0] word;
        input [3:0]  k;
        input [7:0]  comma;
        input [7:0]  id;
        input [7:0]  kind;
        begin
            head_match = (k == `K_COMMA_ONLY) && (word[7:0] == comma) &&
                         (word[15:8] == id) && (word[23:16] == kind);
        end
    endfunction

    reg  [31:0]        ctrl;
    wire [2:0]         tx_mode;
    reg  [`SKIP_W-1:0] skip_count;
    reg  [3:0]         standby_count;
    reg  [7:0]         far_capability;
    reg  [7:0]         far_cause;
    reg                next_inv_clear;
    wire               loss_suppressed;
    wire               loss_active;
    wire [7:0]         cap_sym;
    wire [7:0]         cause_sym;
    wire               bus_req;

    assign tx_mode         = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
    assign loss_suppressed = (standby_count == `STBY_NEEDED);
    assign loss_active     = (rx_no_signal | rx_error_burst) & ~loss_suppressed;
    assign bus_req         = avs_read | avs_write;

    // reserved capability bits go out as zero
    assign cap_sym = {5'h00,
                      ctrl[`CTRL_SCRAM],
                      ctrl[`CTRL_START],
                      ctrl[`CTRL_FLUSH]};

    // weak signal reports 0, so an error burst alone reports 1
    assign cause_sym = {7'h00, rx_error_burst & ~rx_no_signal};

    // avalon slave: one wait state, then the answer stands for one edge
    always @(posedge clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
            ctrl            <= `CTRL_RESET;
            next_inv_clear  <= 1'b0;
        end else begin
            next_inv_clear <= 1'b0;
            if (bus_req && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                case (avs_address)
                    `REG_CTRL: begin
                        avs_readdata <= ctrl;
                    end
                    `REG_STATUS: begin
                        avs_readdata <= {26'h0000000, standby_count,
                                         loss_suppressed, rx_invert};
                    end
                    `REG_RXINFO: begin
                        avs_readdata <= {16'h0000, far_cause, far_capability};
                    end
                    default: begin
                        avs_readdata <= 32'h00000000;
                    end
                endcase
            end else begin
                avs_waitrequest <= 1'b1;
                if (avs_write && !avs_waitrequest && avs_address == `REG_CTRL) begin
                    ctrl           <= {24'h000000, 1'b0, avs_writedata[6:0]};
                    next_inv_clear <= avs_writedata[`CTRL_UNINV];
                end
            end
        end
    end

    // transmit word selection, one word per tx_ready cycle
    always @(posedge clk) begin
        if (rst) begin
            tx_word    <= lane_word(`SYM_K28_7, `SYM_D15_6, `SYM_D15_6);
            tx_k       <= `K_COMMA_ONLY;
            skip_count <= {`SKIP_W{1'b0}};
            ql_ack     <= 1'b0;
        end else begin
            ql_ack <= 1'b0;
            if (tx_ready) begin
                if (skip_count >= SKIP_LAST) begin
                    // skip has top priority so the interval holds in every mode
                    tx_word    <= lane_word(`SYM_K28_7, `SYM_D31_3, `SYM_D31_3);
                    tx_k       <= `K_COMMA_ONLY;
                    skip_count <= {`SKIP_W{1'b0}};
                end else begin
                    skip_count <= skip_count + 1'b1;
                    tx_k       <= `K_COMMA_ONLY;
                    // inverted init patterns have no encoding here at all
                    if (loss_active) begin
                        tx_word <= lane_word(`SYM_K28_7, `SYM_D4_3, cause_sym);
                    end else begin
                        case (tx_mode)
                            `MODE_INIT_WORD_ONE: begin
                                tx_word <= lane_word(`SYM_K28_5, `SYM_D6_2, `SYM_D6_2);
                            end
                            `MODE_INIT_WORD_TWO: begin
                                tx_word <= lane_word(`SYM_K28_5, `SYM_D6_5, `SYM_D6_5);
                            end
                            `MODE_INIT_WORD_THREE: begin
                                tx_word <= lane_word(`SYM_K28_5, `SYM_D24_1, cap_sym);
                            end
                            `MODE_STBY: begin
                                tx_word <= lane_word(`SYM_K28_7, `SYM_D30_3, `SYM_D30_3);
                            end
                            default: begin
                                // an ack is pending while the layer swaps its word
                                if (ctrl[`CTRL_RUN] && ql_valid && !ql_ack) begin
                                    tx_word <= ql_word;
                                    tx_k    <= ql_k;
                                    ql_ack  <= 1'b1;
                                end else begin
                                    tx_word <= lane_word(`SYM_K28_7, `SYM_D15_6, `SYM_D15_6);
                                end
                            end
                        endcase
                    end
                end
            end
        end
    end

    // receive decode; words arriving here are already corrected for inversion
    always @(posedge clk) begin
        if (rst) begin
            rx_invert          <= 1'b0;
            rx_skip_seen       <= 1'b0;
            rx_idle_seen       <= 1'b0;
            rx_init_one_seen   <= 1'b0;
            rx_init_two_seen   <= 1'b0;
            rx_init_three_seen <= 1'b0;
            rx_standby_seen    <= 1'b0;
            rx_loss_seen       <= 1'b0;
            flush_request      <= 1'b0;
            standby_count      <= 4'h0;
            far_capability     <= 8'h00;
            far_cause          <= 8'h00;
        end else begin
            rx_skip_seen       <= 1'b0;
            rx_idle_seen       <= 1'b0;
            rx_init_one_seen   <= 1'b0;
            rx_init_two_seen   <= 1'b0;
            rx_init_three_seen <= 1'b0;
            rx_standby_seen    <= 1'b0;
            rx_loss_seen       <= 1'b0;
            flush_request      <= 1'b0;
            if (next_inv_clear) begin
                rx_invert <= 1'b0;
            end
            if (rx_valid) begin
                if (head_match(rx_word, rx_k, `SYM_K28_5, `SYM_D17_1, `SYM_D25_5) &&
                    rx_word[31:24] == `SYM_D25_5) begin
                    rx_invert <= ~rx_invert;
                end
                if (head_match(rx_word, rx_k, `SYM_K28_5, `SYM_D17_1, `SYM_D25_2) &&
                    rx_word[31:24] == `SYM_D25_2) begin
                    rx_invert <= ~rx_invert;
                end
                if (head_match(rx_word, rx_k, `SYM_K28_7, `SYM_D14_6, `SYM_D31_3) &&
                    rx_word[31:24] == `SYM_D31_3) begin
                    rx_skip_seen <= 1'b1;
                end
                if (head_match(rx_word, rx_k, `SYM_K28_7, `SYM_D14_6, `SYM_D15_6) &&
                    rx_word[31:24] == `SYM_D15_6) begin
                    rx_idle_seen <= 1'b1;
                end
                if (head_match(rx_word, rx_k, `SYM_K28_5, `SYM_D14_6, `SYM_D6_2) &&
                    rx_word[31:24] == `SYM_D6_2) begin
                    rx_init_one_seen <= 1'b1;
                    // a fresh handshake means the far end left standby
                    standby_count    <= 4'h0;
                end
                if (head_match(rx_word, rx_k, `SYM_K28_5, `SYM_D14_6, `SYM_D6_5) &&
                    rx_word[31:24] == `SYM_D6_5) begin
                    rx_init_two_seen <= 1'b1;
                end
                if (head_match(rx_word, rx_k, `SYM_K28_5, `SYM_D14_6, `SYM_D24_1)) begin
                    rx_init_three_seen <= 1'b1;
                    far_capability     <= {5'h00, rx_word[26:24]};
                    flush_request      <= rx_word[24 + `CAP_FLUSH];
                end
                if (head_match(rx_word, rx_k, `SYM_K28_7, `SYM_D14_6, `SYM_D30_3) &&
                    rx_word[31:24] == `SYM_D30_3) begin
                    rx_standby_seen <= 1'b1;
                    if (standby_count != `STBY_NEEDED) begin
                        standby_count <= standby_count + 1'b1;
                    end
                end
                if (head_match(rx_word, rx_k, `SYM_K28_7, `SYM_D14_6, `SYM_D4_3)) begin
                    rx_loss_seen <= 1'b1;
                    far_cause    <= {7'h00, rx_word[24 + `CAUSE_ERRORS]};
                end
            end
        end
    end

endmodule
